// [hw/fbsgc_top.sv]
// fieldbus slave global control, word swap and block transfer logic
//
// Behaviour
// - separation prevention on ignores block instructions
// - software may switch separation prevention off
// - block transfers copy whole area atomically
// - SYNC enters sync mode, each SYNC updates
// - sync mode holds outputs between SYNC services
// - UNSYNC leaves sync mode, outputs follow data
// - FREEZE enters freeze, each FREEZE captures inputs
// - freeze mode holds inputs until next FREEZE
// - UNFREEZE resumes continuous input updating
// - membership in any of eight groups
// - swap exchanges bytes of every word
// - input words swapped before sending
// - received words swapped before storing
// - swap parameter zero off, one on
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// word fifo between link and output staging
// ----------------------------------------
module fbsgc_fifo #(
    parameter int W = 17,
    parameter int D = 8
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic s_valid, // fill side valid
    output logic s_ready, // fill side ready
    input wire logic [W-1:0] s_data, // fill side word
    output logic m_valid, // drain side valid
    input wire logic m_ready, // drain side ready
    output logic [W-1:0] m_data // drain side word
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
        logic ready;
    } fbsgc_fst_t;
    fbsgc_fst_t r, n;
    logic push, pop;

    // pointer and count update, flags kept in flops
    always_comb begin
        n = r;
        push = s_valid && !r.full;
        pop = m_ready && !r.empty;
        if (push) begin
            n.mem[r.wp] = s_data;
            n.wp = r.wp + AW'(1);
        end
        if (pop) begin
            n.rp = r.rp + AW'(1);
        end
        n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        n.full = (n.cnt == (AW+1)'(D));
        n.empty = (n.cnt == '0);
        // ready has its own flop so the top-level port comes straight from a register
        n.ready = (n.cnt != (AW+1)'(D));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{default: '0, empty: 1'b1, ready: 1'b1};
        end else begin
            r <= n;
        end
    end

    assign s_ready = r.ready;
    assign m_valid = !r.empty;
    assign m_data = r.mem[r.rp];
endmodule

// ----------------------------------------
// top: apb slave, link side, global control
// ----------------------------------------
module fbsgc_top import fbsgc_pkg::*; (
    input wire logic pclk, // 10 MHz clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic prm_valid, // parameter set pulse
    input wire logic [7:0] prm_group, // group bits 1..8
    input wire logic [7:0] prm_swap, // swap parameter value
    input wire logic gc_valid, // global control pulse
    input wire fbsgc_gc_t gc_cmd, // service bits
    input wire logic [7:0] gc_group, // selected groups
    input wire logic m_out_valid, // output word valid
    input wire fbsgc_word_t m_out_word, // output word, last flag
    output logic m_out_ready, // fifo can take word
    output fbsgc_area_t m_in_data, // input words to master
    output fbsgc_area_t out_state // output state
);
    typedef struct packed {
        logic sep_en;
        logic ign;
        logic sync_m;
        logic frz_m;
        logic swap;
        logic [NG-1:0] grp;
        fbsgc_area_t stage;
        fbsgc_area_t out_area;
        fbsgc_area_t rd_buf;
        fbsgc_area_t in_area;
        fbsgc_area_t wr_buf;
        fbsgc_area_t in_shown;
        logic [2:0] wptr;
        logic staged;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fbsgc_st_t;
    fbsgc_st_t r, n;

    logic f_valid, drain_rdy, drain, gc_hit, wr_en, blk_rd, blk_wr;
    logic [FIFO_WIDTH-1:0] f_raw;
    fbsgc_word_t f_word;
    logic [2:0] idx;

    // the fifo absorbs master words while a frame waits for SYNC
    fbsgc_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .s_valid(m_out_valid),
        .s_ready(m_out_ready),
        .s_data(m_out_word),
        .m_valid(f_valid),
        .m_ready(drain_rdy),
        .m_data(f_raw)
    );
    assign f_word = f_raw;

    // staging must not be overwritten while a synced frame is pending
    assign drain_rdy = !(r.sync_m && r.staged);
    assign drain = f_valid && drain_rdy;
    assign gc_hit = gc_valid && |(gc_group & r.grp);
    assign idx = paddr[4:2];
    // write lands at the edge where pready is seen high
    assign wr_en = psel && penable && r.pready && pwrite;
    assign blk_wr = wr_en && paddr[7:5] == RG_CSR && paddr[4:0] == A_CMD && pwdata[CMD_WR];
    assign blk_rd = wr_en && paddr[7:5] == RG_CSR && paddr[4:0] == A_CMD && pwdata[CMD_RD];

    // next state of the whole block
    always_comb begin
        n = r;
        // apb answer: one wait state, data prepared before pready
        n.pready = psel && penable && !r.pready;
        if (psel && !r.pready) begin
            n.prdata = '0;
            n.pslverr = 1'b0;
            unique case (paddr[7:5])
                RG_CSR: begin
                    if (paddr[4:0] == A_CTRL) begin
                        n.prdata[CTRL_SEP] = r.sep_en;
                    end else if (paddr[4:0] == A_STAT) begin
                        n.prdata[ST_SYNC] = r.sync_m;
                        n.prdata[ST_FRZ] = r.frz_m;
                        n.prdata[ST_SWAP] = r.swap;
                        n.prdata[ST_IGN] = r.ign;
                        n.prdata[ST_GRP +: NG] = r.grp;
                    end else if (paddr[4:0] != A_CMD) begin
                        n.pslverr = 1'b1;
                    end
                end
                RG_OUT: n.prdata[15:0] = r.out_area[idx];
                RG_RDB: n.prdata[15:0] = r.rd_buf[idx];
                RG_IN: n.prdata[15:0] = r.in_area[idx];
                RG_WRB: n.prdata[15:0] = r.wr_buf[idx];
                default: n.pslverr = 1'b1;
            endcase
        end
        // register writes
        if (wr_en) begin
            unique case (paddr[7:5])
                RG_CSR: begin
                    if (paddr[4:0] == A_CTRL) begin
                        n.sep_en = pwdata[CTRL_SEP];
                    end
                    if (paddr[4:0] == A_STAT && pwdata[ST_IGN]) begin
                        n.ign = 1'b0;
                    end
                end
                RG_IN: n.in_area[idx] = pwdata[15:0];
                RG_WRB: n.wr_buf[idx] = pwdata[15:0];
                default: n.ign = n.ign;
            endcase
        end
        // block instructions: refused under separation prevention
        if (blk_rd || blk_wr) begin
            if (r.sep_en) begin
                n.ign = 1'b1;
            end else begin
                // whole area moves in one edge, no mixed words
                if (blk_rd) begin
                    n.rd_buf = r.out_area;
                end
                if (blk_wr) begin
                    n.in_area = r.wr_buf;
                end
            end
        end
        // received words: swapped, staged, released per mode
        if (drain) begin
            n.stage[r.wptr] = r.swap ? fbsgc_swap16(f_word.data) : f_word.data;
            n.wptr = r.wptr + 3'h1;
            if (f_word.last) begin
                n.wptr = '0;
                if (r.sync_m) begin
                    n.staged = 1'b1;
                end else begin
                    n.out_area = n.stage;
                end
            end
        end
        // output synchronisation services
        if (gc_hit && gc_cmd.unsync) begin
            n.sync_m = 1'b0;
            if (r.staged) begin
                n.out_area = r.stage;
            end
            n.staged = 1'b0;
        end else if (gc_hit && gc_cmd.sync) begin
            n.sync_m = 1'b1;
            if (r.staged) begin
                n.out_area = r.stage;
            end
            n.staged = 1'b0;
        end
        // input view: live unless frozen
        if (gc_hit && gc_cmd.unfreeze) begin
            n.frz_m = 1'b0;
        end else if (gc_hit && gc_cmd.freeze) begin
            n.frz_m = 1'b1;
        end
        if (!r.frz_m || (gc_hit && gc_cmd.freeze && !gc_cmd.unfreeze)) begin
            for (int i = 0; i < NW; i++) begin
                n.in_shown[i] = r.swap ? fbsgc_swap16(r.in_area[i]) : r.in_area[i];
            end
        end
        // parameters from the master
        if (prm_valid) begin
            n.grp = prm_group;
            n.swap = (prm_swap == PRM_SWAP_ON);
        end
    end

    // state register; modes and swap start off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{default: '0, sep_en: CTRL_SEP_RST};
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign m_in_data = r.in_shown;
    assign out_state = r.out_area;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_blk_issued;
        (blk_rd || blk_wr) && r.sep_en;
    endsequence
    sequence s_sync_gap;
        r.sync_m && !gc_hit;
    endsequence

    a_sep_ignore: assert property (s_blk_issued |=> r.ign && $stable(r.rd_buf))
        else $error("block instruction ran under separation prevention");
    a_blk_copy: assert property (blk_rd && !r.sep_en |=> r.rd_buf == $past(r.out_area))
        else $error("block read copy not whole");
    a_sync_enter: assert property (gc_hit && gc_cmd.sync && !gc_cmd.unsync |=> r.sync_m)
        else $error("sync mode not entered");
    a_sync_hold: assert property (s_sync_gap |=> $stable(out_state))
        else $error("outputs moved between sync services");
    a_unsync_leave: assert property (gc_hit && gc_cmd.unsync |=> !r.sync_m)
        else $error("sync mode not left");
    a_freeze_enter: assert property (gc_hit && gc_cmd.freeze && !gc_cmd.unfreeze |=> r.frz_m)
        else $error("freeze mode not entered");
    a_freeze_hold: assert property (r.frz_m && !gc_hit |=> $stable(m_in_data))
        else $error("inputs moved while frozen");
    a_unfreeze_go: assert property (gc_hit && gc_cmd.unfreeze |=> !r.frz_m)
        else $error("freeze mode not left");
    a_foreign_gc: assert property (gc_valid && !gc_hit |=> $stable(r.sync_m) && $stable(r.frz_m))
        else $error("foreign group service acted on");
    a_swap_param: assert property (prm_valid |=> r.swap == ($past(prm_swap) == PRM_SWAP_ON))
        else $error("swap parameter misread");
endmodule
`default_nettype wire

// [hw/fbsgc_pkg.sv]
// shared constants and types of the fieldbus slave data exchange block
package fbsgc_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NW = 8; // words in each data area
    localparam int NG = 8; // group count
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 17;
    // ----------------------------------------
    // apb map: region = paddr[7:5], word index = paddr[4:2]
    // ----------------------------------------
    localparam logic [2:0] RG_CSR = 3'h0; // control and status words
    localparam logic [2:0] RG_OUT = 3'h2; // output receive area, read
    localparam logic [2:0] RG_RDB = 3'h3; // block read buffer, read
    localparam logic [2:0] RG_IN = 3'h4; // input send area, read/write
    localparam logic [2:0] RG_WRB = 3'h5; // block write buffer, read/write
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_CMD = 5'h04;
    localparam logic [4:0] A_STAT = 5'h08;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int CTRL_SEP = 0; // separation prevention enable
    localparam int CMD_RD = 0; // block read instruction
    localparam int CMD_WR = 1; // block write instruction
    localparam int ST_SYNC = 0;
    localparam int ST_FRZ = 1;
    localparam int ST_SWAP = 2;
    localparam int ST_IGN = 3; // instruction ignored, write one to clear
    localparam int ST_GRP = 8; // group membership, 8 bits
    localparam logic CTRL_SEP_RST = 1'b0;
    localparam logic [7:0] PRM_SWAP_ON = 8'h01;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic sync;
        logic unsync;
        logic freeze;
        logic unfreeze;
    } fbsgc_gc_t;
    typedef struct packed {
        logic last;
        logic [15:0] data;
    } fbsgc_word_t;
    typedef logic [NW-1:0][15:0] fbsgc_area_t;
    // high and low byte exchange of one word
    function automatic logic [15:0] fbsgc_swap16(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction
endpackage

// [testbench/fbsgc_master.sv]
// master station model: parameters, global control services, output words
`timescale 1ns/1ps
`default_nettype none
module fbsgc_master import fbsgc_pkg::*; (
    input wire logic pclk, // clock
    input wire logic m_out_ready, // device takes word
    output logic prm_valid, // parameter pulse
    output logic [7:0] prm_group, // group bits
    output logic [7:0] prm_swap, // swap value
    output logic gc_valid, // service pulse
    output fbsgc_gc_t gc_cmd, // service bits
    output logic [7:0] gc_group, // selected groups
    output logic m_out_valid, // word valid
    output fbsgc_word_t m_out_word // word, last flag
);
    // ----
    // released lines show the inverse of the last value
    // ----
    initial begin
        {prm_valid, prm_group, prm_swap, gc_valid, gc_cmd, gc_group, m_out_valid, m_out_word} = '0;
    end
    // groups and swap selection go out as slave parameters
    task automatic prm(input logic [7:0] g, input logic [7:0] s);
        @(posedge pclk);
        prm_valid <= 1'b1;
        prm_group <= g;
        prm_swap <= s;
        @(posedge pclk);
        prm_valid <= 1'b0;
        prm_group <= ~g;
        prm_swap <= ~s;
    endtask
    // multicast service to the selected groups
    task automatic gc(input fbsgc_gc_t c, input logic [7:0] g);
        @(posedge pclk);
        gc_valid <= 1'b1;
        gc_cmd <= c;
        gc_group <= g;
        @(posedge pclk);
        gc_valid <= 1'b0;
        gc_cmd <= fbsgc_gc_t'(~c);
        gc_group <= ~g;
    endtask
    // one word, held up to the rising edge that takes it; bounded wait
    task automatic send(input logic [15:0] d, input logic l, output logic ok);
        int n;
        @(posedge pclk);
        m_out_valid <= 1'b1;
        m_out_word <= {l, d};
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (m_out_ready !== 1'b1 && n < 200);
        ok = (m_out_ready === 1'b1);
        m_out_valid <= 1'b0;
        m_out_word <= ~{l, d};
    endtask
endmodule
`default_nettype wire

// [testbench/fbsgc_top_tb.sv]
// self-checking bench of the fieldbus slave global control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module fbsgc_top_tb import fbsgc_pkg::*; ();
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, prm_valid, gc_valid, m_out_valid, m_out_ready, er, ok;
    logic [7:0] prm_group, prm_swap, gc_group;
    fbsgc_gc_t gc_cmd;
    fbsgc_word_t m_out_word;
    fbsgc_area_t m_in_data, out_state;
    int err_total = 0;
    int check_count = 0;
    logic [15:0] lfsr_r = 16'h003b;
    logic [15:0] in_m[8], out_m[8], shown_m[8], wb_m[8], fa[8], fb[8], fc[8];
    logic swap_m = 1'b0, frz_m = 1'b0, sync_m = 1'b0, ign_m = 1'b0;
    logic [7:0] grp_m = '0;
    always #50 pclk = ~pclk;
    fbsgc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .prm_valid, .prm_group, .prm_swap, .gc_valid, .gc_cmd, .gc_group, .m_out_valid, .m_out_word,
        .m_out_ready, .m_in_data, .out_state);
    fbsgc_master mst (.pclk, .m_out_ready, .prm_valid, .prm_group, .prm_swap, .gc_valid, .gc_cmd,
        .gc_group, .m_out_valid, .m_out_word);
    // ----
    // helpers
    // ----
    function automatic logic [15:0] rnd();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return lfsr_r;
    endfunction
    function automatic logic [15:0] swp(input logic [15:0] w);
        return swap_m ? {w[7:0], w[15:8]} : w;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask
    // apb transfer; pready, read data and error are taken at one rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_stat();
        apb(1'b0, {3'h0, A_STAT}, '0);
        `CHK("stat", {16'h0, grp_m, 4'h0, ign_m, swap_m, frz_m, sync_m}, rd)
    endtask
    task automatic cmp_out();
        for (int i = 0; i < 8; i++) `CHK("out_state", out_m[i], out_state[i])
    endtask
    task automatic cmp_in();
        for (int i = 0; i < 8; i++) `CHK("m_in_data", shown_m[i], m_in_data[i])
    endtask
    // one full frame of random words; stalls are the fifo's to make
    task automatic frame(output logic [15:0] f[8]);
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            f[i] = swp(d);
            mst.send(d, i == 7, ok);
            if (!ok) begin
                err_total++;
                end_of_test();
            end
        end
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        for (int i = 0; i < 8; i++) begin
            in_m[i] = '0;
            out_m[i] = '0;
            shown_m[i] = '0;
        end
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        cyc(1);
        cmp_out();
        cmp_in();
        `CHK("m_out_ready", 1'b1, m_out_ready)
        chk_stat();
        for (int k = 0; k < 2; k++) begin
            mst.prm(8'h05, k[7:0]);
            grp_m = 8'h05;
            swap_m = k[0];
            chk_stat();
        end
        for (int i = 0; i < 8; i++) begin
            in_m[i] = rnd();
            shown_m[i] = swp(in_m[i]);
            apb(1'b1, {RG_IN, i[2:0], 2'b00}, {16'h0, in_m[i]});
        end
        cyc(2);
        cmp_in();
        frame(fa);
        out_m = fa;
        cyc(4);
        cmp_out();
        $display("test params and swap done");
        // sync mode holds a staged frame, the fifo fills behind it
        mst.gc(4'h8, 8'h04);
        sync_m = 1'b1;
        chk_stat();
        frame(fb);
        cyc(4);
        cmp_out();
        frame(fc);
        cyc(2);
        `CHK("m_out_ready", 1'b0, m_out_ready)
        mst.gc(4'h8, 8'h02);
        cyc(2);
        cmp_out();
        mst.gc(4'h8, 8'h01);
        out_m = fb;
        cyc(12);
        cmp_out();
        mst.gc(4'h4, 8'h01);
        sync_m = 1'b0;
        out_m = fc;
        cyc(2);
        cmp_out();
        frame(fa);
        out_m = fa;
        cyc(4);
        cmp_out();
        $display("test sync done");
        mst.gc(4'h2, 8'h04);
        frz_m = 1'b1;
        in_m[0] = rnd();
        apb(1'b1, {RG_IN, 5'h00}, {16'h0, in_m[0]});
        cyc(3);
        cmp_in();
        mst.gc(4'h2, 8'h04);
        shown_m[0] = swp(in_m[0]);
        cyc(2);
        cmp_in();
        chk_stat();
        mst.gc(4'h1, 8'h04);
        frz_m = 1'b0;
        cyc(2);
        chk_stat();
        $display("test freeze done");
        // block instructions refused, then honoured
        apb(1'b1, {3'h0, A_CTRL}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            wb_m[i] = rnd();
            apb(1'b1, {RG_WRB, i[2:0], 2'b00}, {16'h0, wb_m[i]});
        end
        apb(1'b1, {3'h0, A_CMD}, 32'h2);
        ign_m = 1'b1;
        chk_stat();
        apb(1'b0, {RG_IN, 5'h00}, '0);
        `CHK("in_area", {16'h0, in_m[0]}, rd)
        apb(1'b1, {3'h0, A_STAT}, 32'h8);
        ign_m = 1'b0;
        chk_stat();
        apb(1'b1, {3'h0, A_CTRL}, 32'h0);
        apb(1'b1, {3'h0, A_CMD}, 32'h3);
        for (int i = 0; i < 8; i++) begin
            shown_m[i] = swp(wb_m[i]);
            apb(1'b0, {RG_IN, i[2:0], 2'b00}, '0);
            `CHK("in_area", {16'h0, wb_m[i]}, rd)
            apb(1'b0, {RG_RDB, i[2:0], 2'b00}, '0);
            `CHK("rd_buf", {16'h0, out_m[i]}, rd)
        end
        cmp_in();
        apb(1'b0, 8'h20, '0);
        `CHK("pslverr", 1'b1, er)
        `CHK("unmapped", 32'h0, rd)
        $display("test block and map done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {grp_m, swap_m} = '0;
        for (int i = 0; i < 8; i++) begin
            out_m[i] = '0;
            shown_m[i] = '0;
        end
        cyc(1);
        cmp_out();
        cmp_in();
        chk_stat();
        // a swap value other than one leaves words as they are in both directions
        mst.prm(8'h05, 8'h02);
        grp_m = 8'h05;
        chk_stat();
        frame(fa);
        out_m = fa;
        cyc(4);
        cmp_out();
        in_m[1] = rnd();
        shown_m[1] = swp(in_m[1]);
        apb(1'b1, {RG_IN, 5'h04}, {16'h0, in_m[1]});
        cyc(2);
        cmp_in();
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
